// [bench/dac_host_model.sv]
// host model: drives frame select, serial clock and data
module dac_host_model (
  output logic sclk,
  output logic sel_n,
  output logic sdi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk <= 1'b1;
    sel_n <= 1'b1;
    sdi <= 1'b0;
  end
  // nfall falls msb first; falls past 16 carry toggling data; park leaves select low
  task automatic send(input logic [15:0] w, input int nfall, input bit park);
    int i;
    if (sel_n == 1'b0) begin
      sel_n = 1'b1;
      #40;
    end
    sel_n = 1'b0;
    for (i = 0; i < nfall; i++) begin
      sdi = (i < 16) ? w[15-i] : ~sdi;
      #80 sclk = 1'b0;
      #80 sclk = 1'b1;
    end
    if (!park) begin
      sel_n = 1'b1;
      sdi = ~sdi;
      #40;
    end
  endtask
endmodule // dac_host_model

// [bench/dac_port_checker.sv]
// checker: port assertions for the dac serial write port
module dac_port_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic apply_ready,
  input wire logic [dac_port_pkg::CODE_BITS-1:0] dac_code,
  input wire logic power_mode_bit_high,
  input wire logic power_mode_bit_low,
  input wire logic out_enable_n,
  input wire logic out_pull_1k,
  input wire logic out_pull_100k,
  input wire logic update_pulse,
  input wire logic overflow
);
  import dac_port_pkg::*;
  // ****
  // assertions
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_rst;
    disable iff (1'b0) !rst_n && ce |=> dac_code == 12'h000 && !power_mode_bit_high
      && !power_mode_bit_low && !update_pulse;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear in reset");
  property p_code; $past(rst_n) && $changed(dac_code) |-> ##[0:1] update_pulse; endproperty
  a_code: assert property (p_code) else $error("code moved without update");
  property p_mode;
    $past(rst_n) && $changed({power_mode_bit_high, power_mode_bit_low})
      |-> ##[0:1] update_pulse;
  endproperty
  a_mode: assert property (p_mode) else $error("mode moved without update");
  property p_upd; update_pulse |-> $past(apply_ready) || $past(apply_ready, 2); endproperty
  a_upd: assert property (p_upd) else $error("update without consumer ready");
  property p_hiz; out_enable_n == (power_mode_bit_high | power_mode_bit_low); endproperty
  a_hiz: assert property (p_hiz) else $error("output enable wrong");
  property p_1k; out_pull_1k == (!power_mode_bit_high && power_mode_bit_low); endproperty
  a_1k: assert property (p_1k) else $error("1k pull wrong");
  property p_100k; out_pull_100k == (power_mode_bit_high && !power_mode_bit_low); endproperty
  a_100k: assert property (p_100k) else $error("100k pull wrong");
  property p_ovf; overflow |=> overflow; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not sticky");
endmodule // dac_port_checker
bind dac_serial_write_port dac_port_checker i_dac_port_checker (.clk, .rst_n, .ce, .apply_ready,
  .dac_code, .power_mode_bit_high, .power_mode_bit_low, .out_enable_n, .out_pull_1k,
  .out_pull_100k, .update_pulse, .overflow);

// [bench/tb_dac_serial_write_port.sv]
// testbench: frames from the host model, checks code, mode and pull outputs
module tb_dac_serial_write_port;
  import dac_port_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n;
  logic ce = 1'b1;
  logic apply_ready = 1'b1;
  logic sclk, sel_n, sdi, power_mode_bit_high, power_mode_bit_low, out_enable_n;
  logic out_pull_1k, out_pull_100k, update_pulse, overflow;
  logic [CODE_BITS-1:0] dac_code;
  logic [15:0] tbl [4] = '{16'hcfff, 16'hd000, 16'he5a3, 16'hf801};
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int upd_count = 0;
  int k;
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (update_pulse === 1'b1) upd_count++;
  end
  dac_host_model i_dac_host_model (.sclk, .sel_n, .sdi);
  dac_serial_write_port i_dac_serial_write_port (.clk, .rst_n, .ce, .sclk, .sel_n, .sdi,
    .apply_ready, .dac_code, .power_mode_bit_high, .power_mode_bit_low, .out_enable_n,
    .out_pull_1k, .out_pull_100k, .update_pulse, .overflow);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic frame(input logic [15:0] w, input int n, input int npulse, input bit park);
    int u0;
    u0 = upd_count;
    i_dac_host_model.send(w, n, park);
    repeat (8) @(posedge clk);
    chk(16'(upd_count - u0), 16'(npulse));
  endtask
  task automatic expect_out(input logic [15:0] w);
    chk({2'b00, power_mode_bit_high, power_mode_bit_low, dac_code}, {2'b00, w[13:0]});
    chk({13'h0, out_enable_n, out_pull_1k, out_pull_100k},
      {13'h0, |w[13:12], w[13:12] == 2'b01, w[13:12] == 2'b10});
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset;
    chk({2'b00, update_pulse, overflow, dac_code}, 16'h0000);
    expect_out(16'h0000);
    $display("reset test done");
  endtask
  task automatic t_modes;
    for (k = 0; k < 4; k++) begin
      frame(tbl[k], 16, 1, 1'b0);
      expect_out(tbl[k]);
    end
    $display("mode test done");
  endtask
  task automatic t_abort;
    frame(16'h0abc, 16, 1, 1'b0);
    frame(16'h2fff, 15, 0, 1'b0);
    expect_out(16'h0abc);
    frame(16'h1234, 20, 1, 1'b1);
    expect_out(16'h1234);
    frame(16'h0fed, 16, 1, 1'b0);
    expect_out(16'h0fed);
    $display("abort test done");
  endtask
  task automatic t_ce;
    ce <= 1'b0;
    frame(16'h0321, 16, 0, 1'b0);
    expect_out(16'h0fed);
    k = upd_count;
    ce <= 1'b1;
    repeat (8) @(posedge clk);
    chk(16'(upd_count - k), 16'h0001);
    expect_out(16'h0321);
    $display("enable test done");
  endtask
  task automatic t_fifo;
    apply_ready <= 1'b0;
    for (k = 0; k < 9; k++) frame(16'h0100 + 16'(k), 16, 0, 1'b0);
    chk({15'h0, overflow}, 16'h0001);
    expect_out(16'h0321);
    k = upd_count;
    apply_ready <= 1'b1;
    repeat (12) @(posedge clk);
    chk(16'(upd_count - k), 16'h0008);
    expect_out(16'h0107);
    $display("fifo test done");
  endtask
  task automatic t_rerun;
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({2'b00, update_pulse, overflow, dac_code}, 16'h0000);
    expect_out(16'h0000);
    frame(16'hc5a5, 16, 1, 1'b0);
    expect_out(16'hc5a5);
    $display("rerun test done");
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_of_test;
    end
  end
  initial begin
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_modes;
    t_abort;
    t_ce;
    t_fifo;
    t_rerun;
    end_of_test;
  end
endmodule // tb_dac_serial_write_port

// [verilog/dac_port_pkg.sv]
// package: constants and carrier types for the serial write port of the dac
package dac_port_pkg;
  // ****************************************
  // frame layout
  // ****************************************
  localparam int FRAME_BITS = 16;
  localparam int CODE_BITS = 12;
  localparam int MODE_MSB = 13;
  localparam int MODE_LSB = 12;
  localparam int CODE_MSB = 11;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] LAST_BIT = 5'h0f;
  localparam logic [CNT_W-1:0] CNT_DONE = 5'h10;
  localparam logic [CODE_BITS-1:0] CODE_RESET = 12'h000;
  localparam int CODE_FULL_SCALE = 4096;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 40;
  localparam int SEL_HIGH_MIN_NS = 33;
  localparam int SEL_HIGH_MIN_CYC = (SEL_HIGH_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int FIFO_DEPTH = 8;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    mode_normal = 2'h0,
    mode_pd_1k = 2'h1,
    mode_pd_100k = 2'h2,
    mode_pd_hiz = 2'h3
  } power_mode_t;
  typedef struct packed {
    logic power_mode_bit_high;
    logic power_mode_bit_low;
    logic [CODE_BITS-1:0] code;
  } frame_word_t;
  localparam int WORD_W = $bits(frame_word_t);
endpackage

// [verilog/dac_serial_write_port.sv]
// module: top of the dac serial write port, dac register and power mode
// ****************************************
// ****************************************
module dac_serial_write_port #(
  parameter int DEPTH = dac_port_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic sdi,
  input wire logic apply_ready,
  output logic [dac_port_pkg::CODE_BITS-1:0] dac_code,
  output logic power_mode_bit_high,
  output logic power_mode_bit_low,
  output logic out_enable_n,
  output logic out_pull_1k,
  output logic out_pull_100k,
  output logic update_pulse,
  output logic overflow
);
  import dac_port_pkg::*;
  // ****************************************
  // link side
  // ****************************************
  frame_word_t link_word;
  logic link_tgl;
  link_shifter u_shift (
    .sclk(sclk),
    .rst_n(rst_n),
    .sel_n(sel_n),
    .sdi(sdi),
    .word_r(link_word),
    .word_tgl_r(link_tgl)
  );
  // ****************************************
  // crossing: toggle synchronised, word stable long before toggle seen
  // ****************************************
  logic tgl_s1_r;
  logic tgl_s2_r;
  logic tgl_s3_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_s3_r <= 1'b0;
    end else if (ce) begin
      tgl_s1_r <= link_tgl;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
    end
  end
  wire word_event = tgl_s2_r ^ tgl_s3_r;
  // ****************************************
  // fifo of received frames
  // ****************************************
  frame_word_t fifo_out;
  logic fifo_in_ready;
  logic fifo_out_valid;
  wire fifo_pop = fifo_out_valid && apply_ready;
  word_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_data(link_word),
    .in_valid(word_event),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(apply_ready)
  );
  // ****************************************
  // dac register and power mode
  // ****************************************
  function automatic logic [2:0] mode_outputs(input logic [1:0] m);
    // returns {enable_n, pull_1k, pull_100k}
    case (m)
      mode_normal: mode_outputs = 3'h0;
      mode_pd_1k: mode_outputs = 3'h6;
      mode_pd_100k: mode_outputs = 3'h5;
      default: mode_outputs = 3'h4;
    endcase
  endfunction
  wire [1:0] new_mode = {fifo_out.power_mode_bit_high, fifo_out.power_mode_bit_low};
  wire [2:0] new_outs = mode_outputs(new_mode);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dac_code <= CODE_RESET;
      power_mode_bit_high <= 1'b0;
      power_mode_bit_low <= 1'b0;
      out_enable_n <= 1'b0;
      out_pull_1k <= 1'b0;
      out_pull_100k <= 1'b0;
      update_pulse <= 1'b0;
      overflow <= 1'b0;
    end else if (ce) begin
      update_pulse <= fifo_pop;
      if (word_event && !fifo_in_ready) overflow <= 1'b1;
      if (fifo_pop) begin
        dac_code <= fifo_out.code;
        power_mode_bit_high <= fifo_out.power_mode_bit_high;
        power_mode_bit_low <= fifo_out.power_mode_bit_low;
        out_enable_n <= new_outs[2];
        out_pull_1k <= new_outs[1];
        out_pull_100k <= new_outs[0];
      end
    end
  end
endmodule // dac_serial_write_port

// [verilog/link_shifter.sv]
// module: frame shifter on the serial clock, hands words over by toggle
module link_shifter (
  input wire logic sclk,
  input wire logic rst_n,
  input wire logic sel_n,
  input wire logic sdi,
  output dac_port_pkg::frame_word_t word_r,
  output logic word_tgl_r
);
  import dac_port_pkg::*;
  logic [FRAME_BITS-1:0] shift_r;
  logic [CNT_W-1:0] cnt_r;
  wire link_clear = sel_n | ~rst_n;
  wire [FRAME_BITS-1:0] shift_nxt = {shift_r[FRAME_BITS-2:0], sdi};
  wire last_edge = (cnt_r == LAST_BIT);
  // a high frame select clears the frame at once, so an early rise aborts it
  always_ff @(negedge sclk or posedge link_clear) begin
    if (link_clear) begin
      cnt_r <= '0;
      shift_r <= '0;
    end else if (cnt_r != CNT_DONE) begin
      shift_r <= shift_nxt;
      cnt_r <= cnt_r + 1'b1;
    end
  end
  // toggle cleared by system reset while the link idles, so no false word follows
  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      word_tgl_r <= 1'b0;
    end else if (!sel_n && last_edge) begin
      word_tgl_r <= ~word_tgl_r;
    end
  end
  // word held on the link clock only, no reset needed for data
  always_ff @(negedge sclk) begin
    if (!sel_n && last_edge) begin
      word_r <= frame_word_t'(shift_nxt[MODE_MSB:0]);
    end
  end
endmodule // link_shifter

// [verilog/word_fifo.sv]
// module: small flip-flop fifo with valid and ready on both sides
module word_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [AW-1:0] wr_nxt = (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
  wire [AW-1:0] rd_nxt = (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
  assign in_ready = (cnt_r != (AW + 1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_r];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else if (ce) begin
      if (push) wr_r <= wr_nxt;
      if (pop) rd_r <= rd_nxt;
      if (push && !pop) cnt_r <= cnt_r + 1'b1;
      else if (pop && !push) cnt_r <= cnt_r - 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (ce && push) mem_r[wr_r] <= in_data;
  end
endmodule // word_fifo
